// *** logic/mlc_map.svh ***
`ifndef MLC_MAP_SVH
`define MLC_MAP_SVH
// Register offsets (word addresses on the management port)
`define MLC_ADDR_LOOPBACK    16'h8055
`define MLC_ADDR_SOP_CTRL    16'h805A
// Reset values
`define MLC_RST_LOOPBACK     16'h000A
`define MLC_RST_SOP_CTRL     16'h001B
// Loopback control fields
`define MLC_LB_LOCAL_EN      0
`define MLC_LB_LOCAL_TX_SUP  1
`define MLC_LB_REMOTE_EN     2
`define MLC_LB_REMOTE_RX_SUP 3
`define MLC_LB_WIDTH         4
// Start-of-packet control fields
`define MLC_SOP_RX_GEN       0
`define MLC_SOP_RX_SFD       1
`define MLC_SOP_RX_LEN       2
`define MLC_SOP_TX_GEN       3
`define MLC_SOP_TX_SFD       4
`define MLC_SOP_TX_LEN       5
`define MLC_SOP_WIDTH        6
// Preamble bytes before the length fallback fires
`define MLC_PRE_LEN_BYTES    8
// Start-of-frame delimiter byte value
`define MLC_SFD_BYTE         8'hD5
`endif

// *** logic/mlc_pkg.sv ***
package mlc_pkg;
  // Start detector phases within a frame
  typedef enum logic [1:0] {MLC_IDLE, MLC_HUNT, MLC_MARKED, MLC_MISSED} mlc_phase_e;
endpackage

// *** logic/mlc_regs.sv ***
`timescale 1ns/100ps
`include "mlc_map.svh"
module mlc_regs
  import mlc_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic [15:0]               reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [15:0]               reg_rdata,
  output logic      [`MLC_LB_WIDTH-1:0]  lb_ctrl,
  output logic      [`MLC_SOP_WIDTH-1:0] sop_ctrl
);
  // All register state in one struct
  typedef struct packed {
    logic [`MLC_LB_WIDTH-1:0]  lb;
    logic [`MLC_SOP_WIDTH-1:0] sop;
    logic [15:0]               rdata;
  } mlc_regs_s;
  mlc_regs_s st;       // Registered state
  mlc_regs_s next_st;  // Next state

  // Decode writes and prepare read data for the following cycle
  always_comb begin
    next_st = st;
    next_st.rdata = 16'h0000;
    if (reg_wr && reg_addr == `MLC_ADDR_LOOPBACK) begin
      next_st.lb = reg_wdata[`MLC_LB_WIDTH-1:0];
    end
    if (reg_wr && reg_addr == `MLC_ADDR_SOP_CTRL) begin
      next_st.sop = reg_wdata[`MLC_SOP_WIDTH-1:0];
    end
    if (reg_rd) begin
      // Reserved bits and unmapped addresses read as zero
      case (reg_addr)
        `MLC_ADDR_LOOPBACK: next_st.rdata = {12'h000, st.lb};
        `MLC_ADDR_SOP_CTRL: next_st.rdata = {10'h000, st.sop};
        default:            next_st.rdata = 16'h0000;
      endcase
    end
  end

  // Register the state; clock enable freezes everything
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.lb    <= `MLC_LB_WIDTH'(`MLC_RST_LOOPBACK);
      st.sop   <= `MLC_SOP_WIDTH'(`MLC_RST_SOP_CTRL);
      st.rdata <= 16'h0000;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign lb_ctrl   = st.lb;
  assign sop_ctrl  = st.sop;
endmodule

// *** logic/mlc_sop_det.sv ***
`timescale 1ns/100ps
`include "mlc_map.svh"
module mlc_sop_det
  import mlc_pkg::*;
#(
  parameter int PRE_LEN = `MLC_PRE_LEN_BYTES
)(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       gen_en,
  input  wire logic       on_sfd,
  input  wire logic       len_chk,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  output logic            sop
);
  // Detector state in one struct
  typedef struct packed {
    mlc_phase_e phase;
    logic [3:0] cnt;
    logic       sop;
  } mlc_det_s;
  mlc_det_s st;       // Registered state
  mlc_det_s next_st;  // Next state
  logic     sfd_mode; // Delimiter mode needs generation enable too

  assign sfd_mode = gen_en && on_sfd;

  // Frame walk: hunt the delimiter, or mark at valid, or fall back on length
  always_comb begin
    next_st = st;
    if (!valid) begin
      // Indication ends with the frame
      next_st.phase = MLC_IDLE;
      next_st.cnt   = 4'h0;
      next_st.sop   = 1'b0;
    end else begin
      case (st.phase)
        MLC_IDLE: begin
          if (!sfd_mode) begin
            next_st.phase = MLC_MARKED;
            next_st.sop   = gen_en;
          end else if (data == `MLC_SFD_BYTE) begin
            next_st.phase = MLC_MARKED;
            next_st.sop   = 1'b1;
          end else begin
            next_st.phase = MLC_HUNT;
            next_st.cnt   = 4'h1;
          end
        end
        MLC_HUNT: begin
          if (data == `MLC_SFD_BYTE && st.cnt < 4'(PRE_LEN)) begin
            next_st.phase = MLC_MARKED;
            next_st.sop   = 1'b1;
          end else if (st.cnt >= 4'(PRE_LEN)) begin
            // Eight bytes with no delimiter: fallback or give up
            next_st.phase = len_chk ? MLC_MARKED : MLC_MISSED;
            next_st.sop   = len_chk;
          end else begin
            next_st.cnt = st.cnt + 4'h1;
          end
        end
        MLC_MARKED: next_st.sop = st.sop;
        default:    next_st.sop = 1'b0;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.phase <= MLC_IDLE;
      st.cnt   <= 4'h0;
      st.sop   <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sop = st.sop;
endmodule

// *** logic/mlc_top.sv ***
`timescale 1ns/100ps
`include "mlc_map.svh"
// Behaviour
// RULE1 - Local loopback returns transmit data to receive
// RULE2 - Local loopback can block transmit to PHY
// RULE3 - Remote loopback returns line data to transmitter
// RULE4 - Remote loopback can block receive to MAC
// RULE5 - Receive start flag only when generation enabled
// RULE6 - Receive flag at delimiter or at valid
// RULE7 - Receive flag holds until frame end
// RULE8 - Length check raises flag after eight bytes
// RULE9 - Transmit start flag only when generation enabled
// RULE10 - Transmit flag at delimiter in delimiter mode
// RULE11 - Transmit length check bit, off at reset
// RULE12 - Transmit flag mirrors receive behaviour
module mlc_top
  import mlc_pkg::*;
#(
  parameter int PRE_LEN = `MLC_PRE_LEN_BYTES
)(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        mac_tx_en,
  input  wire logic [7:0]  mac_txd,
  output logic             mac_rx_dv,
  output logic      [7:0]  mac_rxd,
  output logic             rx_start_of_packet_flag,
  output logic             tx_start_of_packet_flag,
  input  wire logic        phy_rx_dv,
  input  wire logic [7:0]  phy_rxd,
  output logic             phy_tx_en,
  output logic      [7:0]  phy_txd
);
  logic [`MLC_LB_WIDTH-1:0]  lb_ctrl;   // Loopback settings
  logic [`MLC_SOP_WIDTH-1:0] sop_ctrl;  // Start flag settings
  logic local_en, local_sup, remote_en, remote_sup;

  // Datapath state in one struct
  typedef struct packed {
    logic       rx_dv;
    logic [7:0] rxd;
    logic       tx_en;
    logic [7:0] txd;
  } mlc_path_s;
  mlc_path_s st;       // Registered paths
  mlc_path_s next_st;  // Next paths

  // Register file
  mlc_regs u_regs (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .lb_ctrl   (lb_ctrl),
    .sop_ctrl  (sop_ctrl)
  );

  assign local_en   = lb_ctrl[`MLC_LB_LOCAL_EN];
  assign local_sup  = lb_ctrl[`MLC_LB_LOCAL_TX_SUP];
  assign remote_en  = lb_ctrl[`MLC_LB_REMOTE_EN];
  assign remote_sup = lb_ctrl[`MLC_LB_REMOTE_RX_SUP];

  // Path steering; local loopback takes the MAC receive side if both are on
  always_comb begin
    next_st = st;
    if (local_en) begin
      next_st.rx_dv = mac_tx_en;  // [RULE1]
      next_st.rxd   = mac_txd;
    end else if (remote_en && remote_sup) begin
      next_st.rx_dv = 1'b0;       // [RULE4]
      next_st.rxd   = 8'h00;
    end else begin
      next_st.rx_dv = phy_rx_dv;
      next_st.rxd   = phy_rxd;
    end
    if (remote_en) begin
      next_st.tx_en = phy_rx_dv;  // [RULE3]
      next_st.txd   = phy_rxd;
    end else if (local_en && local_sup) begin
      next_st.tx_en = 1'b0;       // [RULE2]
      next_st.txd   = 8'h00;
    end else begin
      next_st.tx_en = mac_tx_en;
      next_st.txd   = mac_txd;
    end
  end

  // One-cycle registered datapath
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.rx_dv <= 1'b0;
      st.rxd   <= 8'h00;
      st.tx_en <= 1'b0;
      st.txd   <= 8'h00;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign mac_rx_dv = st.rx_dv;
  assign mac_rxd   = st.rxd;
  assign phy_tx_en = st.tx_en;
  assign phy_txd   = st.txd;

  // Receive flag watches what the MAC receives
  mlc_sop_det #(.PRE_LEN(PRE_LEN)) u_rx_det (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .gen_en  (sop_ctrl[`MLC_SOP_RX_GEN]),  // [RULE5]
    .on_sfd  (sop_ctrl[`MLC_SOP_RX_SFD]),  // [RULE6]
    .len_chk (sop_ctrl[`MLC_SOP_RX_LEN]),  // [RULE8]
    .valid   (st.rx_dv),                   // [RULE7]
    .data    (st.rxd),
    .sop     (rx_start_of_packet_flag)
  );

  // Transmit flag watches what goes to the PHY, same rules
  mlc_sop_det #(.PRE_LEN(PRE_LEN)) u_tx_det (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .gen_en  (sop_ctrl[`MLC_SOP_TX_GEN]),  // [RULE9] [RULE12]
    .on_sfd  (sop_ctrl[`MLC_SOP_TX_SFD]),  // [RULE10]
    .len_chk (sop_ctrl[`MLC_SOP_TX_LEN]),  // [RULE11]
    .valid   (st.tx_en),
    .data    (st.txd),
    .sop     (tx_start_of_packet_flag)
  );

  // Assertions
  chk_local_loop_data: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    clk_en && local_en |=> mac_rx_dv == $past(mac_tx_en) && mac_rxd == $past(mac_txd))
    else $error("local loopback data mismatch");
  chk_local_tx_block: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    clk_en && local_en && local_sup && !remote_en |=> !phy_tx_en)
    else $error("looped transmit reached the PHY");
  chk_remote_loop_data: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    clk_en && remote_en |=> phy_tx_en == $past(phy_rx_dv) && phy_txd == $past(phy_rxd))
    else $error("remote loopback data mismatch");
  chk_remote_rx_block: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    clk_en && remote_en && remote_sup && !local_en |=> !mac_rx_dv)
    else $error("received data reached the MAC");
  chk_rx_gen_off: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    !sop_ctrl[`MLC_SOP_RX_GEN] && !rx_start_of_packet_flag && clk_en |=> !rx_start_of_packet_flag)
    else $error("receive flag raised while disabled");
  chk_rx_flag_frame: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    rx_start_of_packet_flag |-> mac_rx_dv || $past(mac_rx_dv))
    else $error("receive flag outside frame");
  chk_rx_flag_hold: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    rx_start_of_packet_flag && mac_rx_dv && clk_en |=> rx_start_of_packet_flag)
    else $error("receive flag dropped inside frame");
  chk_rx_dv_mode: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
    clk_en && sop_ctrl[`MLC_SOP_RX_GEN] && !sop_ctrl[`MLC_SOP_RX_SFD] && mac_rx_dv && !$past(mac_rx_dv)
    |=> rx_start_of_packet_flag)
    else $error("receive flag missed at valid");
  chk_tx_gen_off: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    !sop_ctrl[`MLC_SOP_TX_GEN] && !tx_start_of_packet_flag && clk_en |=> !tx_start_of_packet_flag)
    else $error("transmit flag raised while disabled");
  chk_tx_flag_hold: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
    tx_start_of_packet_flag && phy_tx_en && clk_en |=> tx_start_of_packet_flag)
    else $error("transmit flag dropped inside frame");
  // Transmit side mirrors the receive checks on the PHY-bound stream
  chk_tx_dv_mode: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
    clk_en && sop_ctrl[`MLC_SOP_TX_GEN] && !sop_ctrl[`MLC_SOP_TX_SFD] && phy_tx_en && !$past(phy_tx_en)
    |=> tx_start_of_packet_flag)
    else $error("transmit flag missed at enable");
  chk_tx_flag_frame: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
    tx_start_of_packet_flag |-> phy_tx_en || $past(phy_tx_en))
    else $error("transmit flag outside frame");
  // A low clock enable must hold the valid, flag and read-data outputs where they stand
  chk_stall_freeze: assert property (@(posedge ref_clk) disable iff (rst)
    !clk_en |=> $stable(mac_rx_dv) && $stable(phy_tx_en) && $stable(rx_start_of_packet_flag)
    && $stable(tx_start_of_packet_flag) && $stable(reg_rdata))
    else $error("state moved while clock enable low");
  cov_local_loop: cover property (@(posedge ref_clk) local_en && mac_rx_dv);
  cov_remote_loop: cover property (@(posedge ref_clk) remote_en && phy_tx_en);
  cov_rx_flag: cover property (@(posedge ref_clk) $rose(rx_start_of_packet_flag));
  cov_tx_flag: cover property (@(posedge ref_clk) $rose(tx_start_of_packet_flag));
endmodule

// *** test/mlc_frame_src.sv ***
`timescale 1ns/100ps
// Far-side byte source: plays a MAC transmitter or a PHY receiver
module mlc_frame_src (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [4:0] pre_n,
  input  wire logic       sfd,
  output logic            valid,
  output logic      [7:0] data
);
  logic [4:0] idx;      // Next byte position in the frame
  logic [4:0] pos;      // Position of the byte now being sent
  logic [7:0] byte_out; // Byte for that position
  assign pos = go ? 5'h00 : idx;
  // Preamble, optional delimiter, then payload that never equals the delimiter
  assign byte_out = (pos < pre_n) ? 8'h55 : (pos == pre_n && sfd) ? 8'hD5 : 8'hA0 + {3'h0, pos};
  // Frame is pre_n plus five bytes long
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      valid <= 1'b0;
      data  <= 8'h00;
      idx   <= 5'h00;
    end else if (go || (valid && idx < pre_n + 5'h05)) begin
      valid <= 1'b1;
      data  <= byte_out;
      idx   <= pos + 5'h01;
    end else begin
      // Idle lines flip each cycle so a stale byte is never mistaken for data
      valid <= 1'b0;
      data  <= ~data;
    end
  end
endmodule

// *** test/mlc_top_tb.sv ***
`timescale 1ns/100ps
module mlc_top_tb;
  logic        ref_clk, rst, clk_en, reg_wr, reg_rd, mgo, pgo, sfd;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic        mac_tx_en, mac_rx_dv, phy_rx_dv, phy_tx_en, rx_flag, tx_flag;
  logic [7:0]  mac_txd, mac_rxd, phy_rxd, phy_txd;
  logic [4:0]  pre_n;
  int          mismatches, checks, cycles;
  mlc_top uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd),
    .mac_rx_dv(mac_rx_dv), .mac_rxd(mac_rxd), .rx_start_of_packet_flag(rx_flag),
    .tx_start_of_packet_flag(tx_flag), .phy_rx_dv(phy_rx_dv), .phy_rxd(phy_rxd), .phy_tx_en(phy_tx_en),
    .phy_txd(phy_txd));
  mlc_frame_src mac (.ref_clk(ref_clk), .rst(rst), .go(mgo), .pre_n(pre_n), .sfd(sfd), .valid(mac_tx_en),
    .data(mac_txd));
  mlc_frame_src phy (.ref_clk(ref_clk), .rst(rst), .go(pgo), .pre_n(pre_n), .sfd(sfd), .valid(phy_rx_dv),
    .data(phy_rxd));
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Let one edge pass so a following call never re-drives the strobe in this step
    @(posedge ref_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic test_regs();
    logic [15:0] d;
    reg_read(16'h8055, d); check(d, 16'h000A);
    reg_read(16'h805A, d); check(d, 16'h001B);
    reg_write(16'h8056, 16'hFFFF);
    reg_read(16'h8056, d); check(d, 16'h0000);
    reg_write(16'h8055, 16'hFFFF);
    reg_write(16'h805A, 16'hFFFF);
    reg_read(16'h8055, d); check(d, 16'h000F);
    reg_read(16'h805A, d); check(d, 16'h003F);
    $display("register test done");
  endtask
  // Frames on both streams at once; outputs follow inputs one cycle later
  task automatic run_path(input logic [15:0] lb);
    logic [8:0] mt, pr;
    reg_write(16'h8055, lb);
    pre_n <= 5'd3;
    sfd   <= 1'b1;
    mgo   <= 1'b1;
    pgo   <= 1'b1;
    @(posedge ref_clk);
    mgo <= 1'b0;
    pgo <= 1'b0;
    for (int n = 0; n < 12; n++) begin
      #1 mt = {mac_tx_en, mac_txd};
      pr = {phy_rx_dv, phy_rxd};
      @(posedge ref_clk);
      #1;
      check({7'h0, mac_rx_dv, mac_rxd}, {7'h0, lb[0] ? mt : (lb[2] & lb[3]) ? 9'h0 : pr});
      check({7'h0, phy_tx_en, phy_txd}, {7'h0, lb[2] ? pr : (lb[0] & lb[1]) ? 9'h0 : mt});
    end
    @(posedge ref_clk);
  endtask
  task automatic test_paths();
    logic [15:0] lbs [6] = '{16'h0, 16'h1, 16'h3, 16'h4, 16'hC, 16'hF};
    foreach (lbs[i]) run_path(lbs[i]);
    $display("loopback path test done");
  endtask
  // Offset of the flag rise from the first valid byte, -1 for no flag
  task automatic run_frame(input logic tx, input logic [15:0] sop, input logic [4:0] p, input logic s,
                           input int e);
    int k, f, bad;
    logic dv, fl, pdv;
    k = -1;
    f = -1;
    bad = 0;
    pdv = 1'b0;
    reg_write(16'h805A, sop);
    pre_n <= p;
    sfd   <= s;
    if (tx) mgo <= 1'b1;
    else pgo <= 1'b1;
    @(posedge ref_clk);
    mgo <= 1'b0;
    pgo <= 1'b0;
    for (int n = 0; n < 30; n++) begin
      @(posedge ref_clk);
      #1 dv = tx ? phy_tx_en : mac_rx_dv;
      fl = tx ? tx_flag : rx_flag;
      if (dv === 1'b1 && k < 0) k = n;
      if (fl === 1'b1 && f < 0) f = n;
      // Flag must not drop inside the frame nor linger more than one cycle past its end
      if ((f >= 0 && dv && !fl) || (fl !== 1'b0 && !dv && !pdv)) bad++;
      pdv = dv;
    end
    check(16'(f < 0 ? -1 : f - k), 16'(e));
    check(16'(bad), 16'h0000);
    @(posedge ref_clk);
  endtask
  task automatic test_rx_flag();
    reg_write(16'h8055, 16'h0000);
    run_frame(1'b0, 16'h001B, 5'd7, 1'b1, 8);
    run_frame(1'b0, 16'h0019, 5'd7, 1'b1, 1);
    run_frame(1'b0, 16'h001A, 5'd7, 1'b1, -1);
    run_frame(1'b0, 16'h001F, 5'd12, 1'b0, 9);
    run_frame(1'b0, 16'h001B, 5'd12, 1'b0, -1);
    run_frame(1'b0, 16'h001B, 5'd8, 1'b1, -1);
    $display("receive flag test done");
  endtask
  task automatic test_tx_flag();
    run_frame(1'b1, 16'h001B, 5'd3, 1'b1, 4);
    run_frame(1'b1, 16'h0013, 5'd3, 1'b1, -1);
    run_frame(1'b1, 16'h000B, 5'd3, 1'b1, 1);
    run_frame(1'b1, 16'h003B, 5'd12, 1'b0, 9);
    run_frame(1'b1, 16'h001B, 5'd12, 1'b0, -1);
    $display("transmit flag test done");
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mgo = 1'b0;
    pgo = 1'b0;
    pre_n = 5'd3;
    sfd = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    test_regs();
    test_paths();
    test_rx_flag();
    test_tx_flag();
    summarize();
  end
endmodule
